// [tb/timer_channel_mode_control_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module timer_channel_mode_control_tb_top;
   import timer_mode_pkg::*;
   logic mclk, rst;
   reg_req_s req;
   logic [7:0] rdata, got;
   logic [2:0] counting, c_raw, d_raw, p_raw, c_ev, d_ev, p_use, wwc;
   chan_cfg_s [2:0] cfg;
   int miscompares, samples_checked;
   timer_channel_mode_control timer_channel_mode_control_inst (
      .mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
      .counting(counting), .c_event_raw(c_raw), .d_event_raw(d_raw),
      .prescaler_use_raw(p_raw), .c_event(c_ev), .d_event(d_ev),
      .prescaler_use(p_use), .cfg(cfg), .write_while_counting(wwc));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task chk(input logic [7:0] g, input logic [7:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe is taken
   task rd(input logic [1:0] a);
      @(posedge mclk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 got = rdata;
   endtask : rd
   task settle;
      @(posedge mclk);
      #1;
   endtask : settle
   task t_reset;
      for (int i = 0; i < 3; i++) begin
         rd(i[1:0]);
         chk(got, 8'hc0, "reset value");
         chk({5'h0, cfg[i].mode}, 8'h00, "reset mode");
      end
      $display("test reset done");
   endtask : t_reset
   task t_buf;
      wr(2'h0, 8'h30);
      rd(2'h0);
      chk(got, 8'hf0, "ch0 buffers");
      chk({6'h0, cfg[0].buf_a, cfg[0].buf_b}, 8'h03, "buf cfg");
      chk({6'h0, c_ev[0], d_ev[0]}, 8'h00, "events masked");
      wr(2'h0, 8'h10);
      settle;
      chk({6'h0, c_ev[0], d_ev[0]}, 8'h01, "only c masked");
      wr(2'h0, 8'h00);
      rd(2'h0);
      chk(got, 8'hc0, "top bits stay");
      chk({6'h0, c_ev[0], d_ev[0]}, 8'h03, "events pass");
      $display("test buffer done");
   endtask : t_buf
   task t_ch12;
      for (int i = 1; i < 3; i++) begin
         wr(i[1:0], 8'h37);
         rd(i[1:0]);
         chk(got, 8'hc7, "no buffer bits");
         chk({6'h0, c_ev[i], d_ev[i]}, 8'h03, "no masking");
         wr(i[1:0], 8'h00);
      end
      // Write then read with no gap between the strobes
      @(posedge mclk);
      req <= '{2'h1, 8'h36, 1'b1, 1'b0};
      @(posedge mclk);
      req <= '{2'h1, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      req <= '0;
      #1 got = rdata;
      chk(got, 8'hc6, "back to back readback");
      wr(2'h1, 8'h00);
      $display("test channels 1 2 done");
   endtask : t_ch12
   task t_modes;
      for (int m = 0; m < 9; m++) begin
         wr(2'h1, m[7:0]);
         settle;
         chk({5'h0, cfg[1].mode}, {5'h0, m[2:0]}, "mode");
         chk({7'h0, cfg[1].pwm}, {7'h0, m == 2 || m == 3}, "pwm");
         chk({7'h0, cfg[1].phase_count}, {7'h0, m[2]}, "phase");
         chk({7'h0, cfg[1].prohibited}, {7'h0, m[3]}, "md3");
         chk({5'h0, p_use}, {5'h0, 1'b1, ~m[2], 1'b1}, "prescaler");
      end
      wr(2'h1, 8'h00);
      $display("test modes done");
   endtask : t_modes
   task t_flag;
      counting <= 3'b100;
      wr(2'h2, 8'h01);
      counting <= 3'b000;
      rd(2'h3);
      chk(got, 8'h04, "write while counting");
      $display("test flag done");
   endtask : t_flag
   task close_out;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   initial begin
      rst = 1'b1;
      req = '0;
      counting = 3'b000;
      c_raw = 3'b111;
      d_raw = 3'b111;
      p_raw = 3'b111;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_buf;
      t_ch12;
      t_modes;
      t_flag;
      close_out;
   end
   initial begin
      repeat (2000) @(posedge mclk);
      miscompares++;
      close_out;
   end
endmodule : timer_channel_mode_control_tb_top
`default_nettype wire

// [verilog/timer_channel_mode_control.sv]
`timescale 1ns/100ps
`default_nettype none
`include "timer_mode_params.svh"
module timer_channel_mode_control (
   input wire logic mclk,
   input wire logic rst,
   input wire timer_mode_pkg::reg_req_s req,
   output logic [7:0] rdata,
   input wire logic [`CH_COUNT-1:0] counting,
   input wire logic [`CH_COUNT-1:0] c_event_raw,
   input wire logic [`CH_COUNT-1:0] d_event_raw,
   input wire logic [`CH_COUNT-1:0] prescaler_use_raw,
   output logic [`CH_COUNT-1:0] c_event,
   output logic [`CH_COUNT-1:0] d_event,
   output logic [`CH_COUNT-1:0] prescaler_use,
   output timer_mode_pkg::chan_cfg_s [`CH_COUNT-1:0] cfg,
   output logic [`CH_COUNT-1:0] write_while_counting
);
   import timer_mode_pkg::*;

   logic [7:0] channel_mode_register [`CH_COUNT];
   logic [7:0] next_rdata;
   logic [`CH_COUNT-1:0] hit;
   logic [`CH_COUNT-1:0] late_write;

   always_comb begin
      hit = '0;
      if (req.addr == `MODE_REG_CH0) begin
         hit[0] = 1'b1;
      end else if (req.addr == `MODE_REG_CH1) begin
         hit[1] = 1'b1;
      end else if (req.addr == `MODE_REG_CH2) begin
         hit[2] = 1'b1;
      end
   end

   // All eight bits are stored; fixed bits are forced from the constants on reset and on every write.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `CH_COUNT; i++) begin
            channel_mode_register[i] <= `MODE_RESET;
         end
      end else if (req.wr) begin
         for (int i = 0; i < `CH_COUNT; i++) begin
            if (hit[i]) begin
               if (i == 0) begin
                  channel_mode_register[i] <= `RESERVED_HI |
                     (req.wdata & `WR_MASK_CH0);
               end else begin
                  channel_mode_register[i] <= `RESERVED_HI |
                     (req.wdata & `WR_MASK_CH12);
               end
            end
         end
      end
   end

   // Writes during counting are accepted but flagged, since software
   // is expected to halt the channel first.
   always_comb begin
      late_write = hit & counting & {`CH_COUNT{req.wr}};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         write_while_counting <= '0;
      end else begin
         write_while_counting <= write_while_counting | late_write;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (req.addr == `MODE_REG_CH0) begin
         next_rdata = channel_mode_register[0];
      end else if (req.addr == `MODE_REG_CH1) begin
         next_rdata = channel_mode_register[1];
      end else if (req.addr == `MODE_REG_CH2) begin
         next_rdata = channel_mode_register[2];
      end else if (req.addr == `STATUS_REG) begin
         next_rdata = {5'h00, write_while_counting};
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 8'h00;
      end
   end

   always_comb begin
      for (int i = 0; i < `CH_COUNT; i++) begin
         cfg[i].mode = op_mode_e'(channel_mode_register[i][2:0]);
         cfg[i].prohibited = channel_mode_register[i][`BIT_MD3];
         cfg[i].phase_count = channel_mode_register[i][`BIT_MD2] &
            ~channel_mode_register[i][`BIT_MD3];
         cfg[i].pwm = (channel_mode_register[i][3:1] == 3'h1);
         cfg[i].buf_b = channel_mode_register[i][`BIT_BUF_B];
         cfg[i].buf_a = channel_mode_register[i][`BIT_BUF_A];
         cfg[i].prescaler_ignore = (i == 1) && cfg[i].phase_count;
         d_event[i] = d_event_raw[i] & ~cfg[i].buf_b;
         c_event[i] = c_event_raw[i] & ~cfg[i].buf_a;
         prescaler_use[i] = prescaler_use_raw[i] &
            ~cfg[i].prescaler_ignore;
      end
   end

   // Fixed top bits are stored as ones and read back as ones.
   AST_RESERVED_HIGH: assert property (@(posedge mclk)
      disable iff (rst)
      req.rd |=> rdata[7:6] == 2'b11 || $past(req.addr) == `STATUS_REG)
      else $error("reserved high bits not read as one");
   AST_CH0_TOP_ONES: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[0][7:6] == 2'b11)
      else $error("channel 0 top bits not one");
   AST_CH1_TOP_ONES: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[1][7:6] == 2'b11)
      else $error("channel 1 top bits not one");
   AST_CH2_TOP_ONES: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[2][7:6] == 2'b11)
      else $error("channel 2 top bits not one");

   // Write path: only the bits that a channel owns take the new value.
   AST_WRITE_CH0: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH0 |=> channel_mode_register[0] ==
      (8'hc0 | ($past(req.wdata) & 8'h3f)))
      else $error("channel 0 write not stored");
   AST_WRITE_CH1: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH1 |=> channel_mode_register[1] ==
      (8'hc0 | ($past(req.wdata) & 8'h0f)))
      else $error("channel 1 write not stored");
   AST_WRITE_CH2: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH2 |=> channel_mode_register[2] ==
      (8'hc0 | ($past(req.wdata) & 8'h0f)))
      else $error("channel 2 write not stored");
   AST_BUF_B_FOLLOWS: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH0 |=>
      cfg[0].buf_b == $past(req.wdata[5]))
      else $error("channel 0 B pairing not taken from write");
   AST_BUF_A_FOLLOWS: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH0 |=>
      cfg[0].buf_a == $past(req.wdata[4]))
      else $error("channel 0 A pairing not taken from write");

   // Event gating: a register acting as buffer raises no event at all.
   AST_D_BLOCK: assert property (@(posedge mclk)
      disable iff (rst)
      cfg[0].buf_b |-> !d_event[0])
      else $error("register D event passed while buffered");
   AST_D_PASS: assert property (@(posedge mclk)
      disable iff (rst)
      !cfg[0].buf_b |-> d_event[0] == d_event_raw[0])
      else $error("register D event lost without buffering");
   AST_C_BLOCK: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[0][4] && c_event_raw[0] |-> !c_event[0])
      else $error("register C event passed while buffered");
   AST_C_PASS: assert property (@(posedge mclk)
      disable iff (rst)
      !cfg[0].buf_a |-> c_event[0] == c_event_raw[0])
      else $error("register C event lost without buffering");
   AST_CH1_BUF_ZERO: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[1][5:4] == 2'b00)
      else $error("channel 1 buffer bits not zero");
   AST_CH2_BUF_ZERO: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[2][5:4] == 2'b00)
      else $error("channel 2 buffer bits not zero");
   AST_CH12_D_PASS: assert property (@(posedge mclk)
      disable iff (rst)
      d_event[2:1] == d_event_raw[2:1])
      else $error("channel 1 or 2 D event masked");
   AST_CH12_C_PASS: assert property (@(posedge mclk)
      disable iff (rst)
      c_event[2:1] == c_event_raw[2:1])
      else $error("channel 1 or 2 C event masked");

   // Mode decode from the low four bits of each register.
   AST_READBACK: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH1 ##1 req.rd &&
      req.addr == `MODE_REG_CH1 && !req.wr |=>
      rdata == (8'hc0 | ($past(req.wdata, 2) & 8'h0f)))
      else $error("channel 1 readback wrong");
   AST_NORMAL_MODE: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[1][3:0] == 4'h0 |->
      cfg[1].mode == MODE_NORMAL && !cfg[1].pwm && !cfg[1].phase_count)
      else $error("normal mode not decoded");
   AST_PWM_CH1: assert property (@(posedge mclk)
      disable iff (rst)
      cfg[1].pwm == (channel_mode_register[1][3:0] == 4'h2 ||
      channel_mode_register[1][3:0] == 4'h3))
      else $error("PWM mode not decoded");
   AST_MODE_FIELD_CH2: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH2 |=>
      cfg[2].mode == op_mode_e'($past(req.wdata[2:0])))
      else $error("channel 2 mode field not decoded");
   AST_PHASE_DECODE: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[1][3:2] == 2'b01 |->
      cfg[1].phase_count && cfg[1].mode >= MODE_PHASE1)
      else $error("phase counting not decoded");
   AST_NO_PHASE_MD2_LOW: assert property (@(posedge mclk)
      disable iff (rst)
      !channel_mode_register[1][`BIT_MD2] |-> !cfg[1].phase_count)
      else $error("phase counting decoded with bit 2 clear");
   AST_PHASE_ORDER: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[2][3:0] == 4'h7 |-> cfg[2].mode == MODE_PHASE4)
      else $error("phase counting modes out of order");
   AST_PROHIBITED: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[1][`BIT_MD3] |->
      cfg[1].prohibited && !cfg[1].phase_count && !cfg[1].pwm)
      else $error("prohibited mode not flagged");

   // Prescaler gating applies to channel 1 only.
   AST_PHASE: assert property (@(posedge mclk)
      disable iff (rst)
      channel_mode_register[1][3:2] == 2'b01 && prescaler_use_raw[1]
      |-> !prescaler_use[1] && cfg[1].phase_count)
      else $error("prescaler not ignored in phase counting");
   AST_PRESCALER_PASS: assert property (@(posedge mclk)
      disable iff (rst)
      !cfg[1].phase_count |-> prescaler_use[1] == prescaler_use_raw[1])
      else $error("channel 1 prescaler dropped outside phase counting");
   AST_PRESCALER_OTHERS: assert property (@(posedge mclk)
      disable iff (rst)
      prescaler_use[0] == prescaler_use_raw[0] &&
      prescaler_use[2] == prescaler_use_raw[2])
      else $error("channel 0 or 2 prescaler altered");

   // No disable here: these look at the very edge that ends reset.
   AST_RESET: assert property (@(posedge mclk)
      $fell(rst) |-> channel_mode_register[2] == 8'hc0)
      else $error("mode register not at reset value");
   AST_RESET_CH0: assert property (@(posedge mclk)
      $fell(rst) |-> channel_mode_register[0] == 8'hc0)
      else $error("channel 0 register not at reset value");
   AST_RESET_CH1: assert property (@(posedge mclk)
      $fell(rst) |-> channel_mode_register[1] == 8'hc0)
      else $error("channel 1 register not at reset value");
   AST_RESET_CFG: assert property (@(posedge mclk)
      $fell(rst) |-> cfg[0].mode == MODE_NORMAL && !cfg[0].buf_a &&
      !cfg[0].buf_b && !cfg[0].prohibited)
      else $error("channel 0 not in normal mode after reset");

   // Late-write flag is sticky so that software can poll it afterwards.
   AST_LATE_FLAG: assert property (@(posedge mclk)
      disable iff (rst)
      req.wr && req.addr == `MODE_REG_CH2 && counting[2]
      |=> write_while_counting[2])
      else $error("late write not flagged");
   AST_FLAG_STICKY: assert property (@(posedge mclk)
      disable iff (rst)
      write_while_counting[2] |=> write_while_counting[2])
      else $error("late-write flag cleared without reset");
   AST_NO_FLAG_HALTED: assert property (@(posedge mclk)
      disable iff (rst)
      !counting[0] && !write_while_counting[0] |=> !write_while_counting[0])
      else $error("late-write flag set while halted");
   AST_STATUS_READ: assert property (@(posedge mclk)
      disable iff (rst)
      req.rd && req.addr == `STATUS_REG |=>
      rdata == {5'h00, $past(write_while_counting)})
      else $error("status read does not show late-write flags");

   // Main scenarios that the bench is expected to reach.
   COV_BUF_A: cover property (@(posedge mclk) disable iff (rst)
      cfg[0].buf_a && c_event_raw[0]);
   COV_PWM2: cover property (@(posedge mclk) disable iff (rst)
      cfg[1].mode == MODE_PWM2 && cfg[1].pwm);
   COV_PHASE4: cover property (@(posedge mclk) disable iff (rst)
      cfg[1].mode == MODE_PHASE4 && cfg[1].phase_count);
   COV_PROHIBITED: cover property (@(posedge mclk) disable iff (rst)
      cfg[1].prohibited);
   COV_LATE_WRITE: cover property (@(posedge mclk) disable iff (rst)
      write_while_counting != 3'b000);
endmodule : timer_channel_mode_control
`default_nettype wire

// [verilog/timer_mode_params.svh]
`ifndef TIMER_MODE_PARAMS_SVH
`define TIMER_MODE_PARAMS_SVH
`define CH_COUNT 3
`define ADDR_W 2
`define MODE_REG_CH0 2'h0
`define MODE_REG_CH1 2'h1
`define MODE_REG_CH2 2'h2
`define STATUS_REG 2'h3
`define BIT_BUF_B 5
`define BIT_BUF_A 4
`define BIT_MD3 3
`define BIT_MD2 2
`define RESERVED_HI 8'hc0
`define MODE_RESET 8'hc0
`define WR_MASK_CH0 8'h3f
`define WR_MASK_CH12 8'h0f
`endif

// [verilog/timer_mode_pkg.sv]
`default_nettype none
package timer_mode_pkg;
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b000,
      MODE_RESERVED = 3'b001,
      MODE_PWM1 = 3'b010,
      MODE_PWM2 = 3'b011,
      MODE_PHASE1 = 3'b100,
      MODE_PHASE2 = 3'b101,
      MODE_PHASE3 = 3'b110,
      MODE_PHASE4 = 3'b111
   } op_mode_e;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   typedef struct packed {
      op_mode_e mode;
      logic prohibited;
      logic phase_count;
      logic pwm;
      logic buf_a;
      logic buf_b;
      logic prescaler_ignore;
   } chan_cfg_s;
endpackage : timer_mode_pkg
`default_nettype wire
